// ---- adc_hs_consts.svh ----
`ifndef ADC_HS_CONSTS_SVH
`define ADC_HS_CONSTS_SVH

// Internal clock scaling
`define DIV_RATIO 58

// Conversion phase lengths in internal clock periods
`define AZ_PERIODS 2048
`define INT_PERIODS 2048
`define DEINT_PERIODS 4096
`define PHASE_CNT_W 13

// Register byte offsets
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_DATA 8'h08

// Control register fields
`define CTRL_TRIG 0
`define CTRL_RUN 1
`define CTRL_RESET 32'h0000_0002

// Status register fields
`define STAT_HS 0
`define STAT_CONV 1
`define STAT_MODE 2
`define STAT_READY 3

// Data word layout
`define DATA_W 14
`define DATA_LOW_MSB 7
`define DATA_HIGH_LSB 8

// Control pins idle level (load, upper, lower all high)
`define CTL_IDLE 3'h7

`endif

// ---- adc_hs_pkg.sv ----
package adc_hs_pkg;

    // Chip-enable/load and the two byte enables
    typedef struct packed {
        logic load;
        logic upper;
        logic lower;
    } ctl_pins_s;

    // Internal clock level and its edges as one-cycle ticks
    typedef struct packed {
        logic level;
        logic rise;
        logic fall;
    } iclk_s;

    typedef enum {
        HS_IDLE,
        HS_WAIT_HI,
        HS_ARM_HI,
        HS_LOAD_HI,
        HS_HOLD_HI,
        HS_GAP_HI,
        HS_LOAD_LO,
        HS_HOLD_LO,
        HS_GAP_LO
    } hs_state_e;

    typedef enum {
        PH_AZ,
        PH_INT,
        PH_DE
    } conv_phase_e;

endpackage

// ---- clock_scaler.sv ----
`timescale 1ns/10ps
`include "adc_hs_consts.svh"

module clock_scaler
    import adc_hs_pkg::*;
#(
    parameter int DIV_RATIO = `DIV_RATIO
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Oscillator pins
    input wire logic osc_pin,
    input wire logic select_pin,
    // Internal clock
    output iclk_s iclk
);

    localparam int CW = $clog2(DIV_RATIO);
    localparam logic [CW-1:0] HALF_LAST = CW'(DIV_RATIO / 2 - 1);

    if (DIV_RATIO < 2 || DIV_RATIO % 2 != 0) begin : g_bad_ratio
        $error("DIV_RATIO must be even and at least 2");
    end

    logic [1:0] meta;
    logic [1:0] sync;
    logic osc_prev;
    logic [CW-1:0] cnt;
    logic div_lvl;
    logic osc_s;
    logic sel_s;
    logic osc_rise;
    logic next_level;

    assign osc_s = sync[0];
    assign sel_s = sync[1];
    assign osc_rise = osc_s & ~osc_prev;
    // Select high: pass through; low: divided level
    assign next_level = sel_s ? osc_s : div_lvl; // [RQ16] [RQ17]

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            meta <= '0;
            sync <= '0;
            osc_prev <= '0;
        end else begin
            meta <= {select_pin, osc_pin}; // [RQ20]
            sync <= meta;
            osc_prev <= osc_s;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cnt <= '0;
            div_lvl <= '0;
        end else if (osc_rise) begin
            if (cnt == HALF_LAST) begin
                cnt <= '0;
                div_lvl <= ~div_lvl; // [RQ17]
            end else begin
                cnt <= cnt + CW'(1);
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            iclk <= '0;
        end else begin
            iclk.level <= next_level;
            iclk.rise <= next_level & ~iclk.level;
            iclk.fall <= ~next_level & iclk.level;
        end
    end

    AST_PASS_THROUGH: assert property (@(posedge clk) disable iff (reset)
        $past(sel_s) |-> iclk.level == $past(osc_s)) // [RQ16]
        else $error("internal clock does not follow oscillator");

    AST_DIVIDE_TOGGLE: assert property (@(posedge clk) disable iff (reset)
        (osc_rise && cnt == HALF_LAST) |=> div_lvl != $past(div_lvl)) // [RQ17]
        else $error("divided clock missed its toggle");

endmodule

// ---- adc_handshake_output_sequencer.sv ----
// Functional notes
// RQ1 - Mode held high: enter handshake after each fresh latch update.
// RQ2 - Rising edge of a mode pulse enters handshake immediately.
// RQ3 - Trigger during latching waits until latched data is stable.
// RQ4 - In handshake: mode ignored, latch updates suppressed, results lost.
// RQ5 - Handshake or mode high: control pins driven as outputs.
// RQ6 - Ready sampled on internal falling edges, including the entry edge.
// RQ7 - Rise after ready: load and upper enable low, high byte driven.
// RQ8 - Load low one period; byte data driven one and half periods.
// RQ9 - Then low byte with lower enable; leave after both bytes.
// RQ10 - Ready low after load stalls with enable low, data driven.
// RQ11 - Ready high: high data off, half later low byte starts.
// RQ12 - After low byte: data off, half later pins return high.
// RQ13 - Ready low at entry: wait, first byte paced like second.
// RQ14 - Conversions, status and run/hold keep working during handshake.
// RQ15 - Receiver drives ready high only when it can take a byte.
// RQ16 - Select high: internal clock equals oscillator, no division.
// RQ17 - Select low: internal clock is oscillator divided by 58.
// RQ18 - Signal integration lasts 2048 internal clock periods.
// RQ19 - Pulse-triggered and mode low after: pins become inputs again.
// RQ20 - Ready and mode inputs synchronised before use.
`timescale 1ns/10ps
`include "adc_hs_consts.svh"

module adc_handshake_output_sequencer
    import adc_hs_pkg::*;
#(
    parameter int AZ_PERIODS = `AZ_PERIODS,
    parameter int INT_PERIODS = `INT_PERIODS,
    parameter int DEINT_PERIODS = `DEINT_PERIODS,
    parameter int DIV_RATIO = `DIV_RATIO
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET,
    // Wishbone slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    // Oscillator
    input wire logic OSC_IN,
    input wire logic OSC_SELECT,
    // Converter
    input wire logic RUN_HOLD,
    input wire logic [`DATA_W-1:0] CONV_RESULT,
    output logic STATUS,
    // Handshake control
    input wire logic MODE,
    input wire logic TX_BUFFER_EMPTY,
    input wire ctl_pins_s CTL_IN,
    output ctl_pins_s CTL_OUT,
    output ctl_pins_s CTL_OE,
    // Data pins
    output logic [`DATA_W-1:0] DATA_OUT,
    output logic [1:0] DATA_OE
);

    localparam int CW = `PHASE_CNT_W;
    localparam logic [CW-1:0] AZ_LAST = CW'(AZ_PERIODS - 1);
    localparam logic [CW-1:0] INT_LAST = CW'(INT_PERIODS - 1);
    localparam logic [CW-1:0] DE_LAST = CW'(DEINT_PERIODS - 1);
    localparam logic [31:0] CTRL_INIT = `CTRL_RESET;

    if (AZ_PERIODS < 1 || AZ_PERIODS > 2**CW || INT_PERIODS < 1 ||
        INT_PERIODS > 2**CW || DEINT_PERIODS < 1 ||
        DEINT_PERIODS > 2**CW) begin : g_bad_len
        $error("phase lengths must lie in 1 to 8192");
    end

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RESET);

    ////////////////////////////////////////////////////////////////////
    // Input synchronisers

    logic [5:0] meta;
    logic [5:0] sync;
    logic mode_s;
    logic ready_s;
    logic run_s;
    logic ce_s;
    logic ube_s;
    logic lbe_s;
    logic mode_prev;
    logic mode_rise;

    assign {mode_s, ready_s, run_s, ce_s, ube_s, lbe_s} = sync;
    assign mode_rise = mode_s & ~mode_prev;

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            // Pins at their pull levels, no false enable after reset
            meta <= 6'h0f;
            sync <= 6'h0f;
            mode_prev <= '0;
        end else begin
            meta <= {MODE, TX_BUFFER_EMPTY, RUN_HOLD, CTL_IN}; // [RQ20]
            sync <= meta;
            mode_prev <= mode_s;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Internal clock

    iclk_s iclk;

    clock_scaler #(
        .DIV_RATIO(DIV_RATIO)
    ) u_scaler (
        .clk(CLK),
        .reset(RESET),
        .osc_pin(OSC_IN),
        .select_pin(OSC_SELECT),
        .iclk(iclk)
    );

    ////////////////////////////////////////////////////////////////////
    // Register bus

    logic ctrl_run;
    logic sw_trig;
    logic bus_req;
    logic [31:0] rd_data;
    hs_state_e hs;
    hs_state_e next_hs;
    conv_phase_e phase;
    logic [CW-1:0] cnt;
    logic [`DATA_W-1:0] data_latch;
    logic fresh;

    assign bus_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            WB_ACK_O <= '0;
        end else begin
            WB_ACK_O <= bus_req;
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            ctrl_run <= CTRL_INIT[`CTRL_RUN];
            sw_trig <= '0;
        end else begin
            sw_trig <= '0;
            if (bus_req && WB_WE_I && WB_SEL_I[0] &&
                WB_ADR_I == `REG_CTRL) begin
                ctrl_run <= WB_DAT_I[`CTRL_RUN];
                sw_trig <= WB_DAT_I[`CTRL_TRIG];
            end
        end
    end

    always_comb begin
        rd_data = '0;
        case (WB_ADR_I)
            `REG_CTRL: rd_data[`CTRL_RUN] = ctrl_run;
            `REG_STATUS: begin
                rd_data[`STAT_HS] = (hs != HS_IDLE);
                rd_data[`STAT_CONV] = STATUS;
                rd_data[`STAT_MODE] = mode_s;
                rd_data[`STAT_READY] = ready_s;
            end
            `REG_DATA: rd_data[`DATA_W-1:0] = data_latch;
            default: rd_data = '0;
        endcase
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            WB_DAT_O <= '0;
        end else if (bus_req && !WB_WE_I) begin
            WB_DAT_O <= rd_data;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Conversion sequencer

    logic run_ok;
    logic int_start;
    logic conv_end;

    assign run_ok = run_s & ctrl_run;
    assign int_start = iclk.rise && phase == PH_AZ && cnt == AZ_LAST &&
        run_ok;

    // Runs whatever the handshake does
    always_ff @(posedge CLK or posedge RESET) begin // [RQ14]
        if (RESET) begin
            phase <= PH_AZ;
            cnt <= '0;
            data_latch <= '0;
            fresh <= '0;
            conv_end <= '0;
        end else if (iclk.rise) begin
            case (phase)
                PH_AZ: begin
                    if (cnt != AZ_LAST) begin
                        cnt <= cnt + CW'(1);
                    end else if (run_ok) begin
                        phase <= PH_INT;
                        cnt <= '0;
                    end
                end
                PH_INT: begin
                    if (cnt == INT_LAST) begin // [RQ18]
                        phase <= PH_DE;
                        cnt <= '0;
                    end else begin
                        cnt <= cnt + CW'(1);
                    end
                end
                PH_DE: begin
                    if (cnt == DE_LAST) begin
                        phase <= PH_AZ;
                        cnt <= '0;
                        conv_end <= '1;
                        if (hs == HS_IDLE) begin // [RQ4]
                            data_latch <= CONV_RESULT;
                            fresh <= '1;
                        end
                    end else begin
                        cnt <= cnt + CW'(1);
                    end
                end
                default: phase <= PH_AZ;
            endcase
        end else if (iclk.fall) begin
            fresh <= '0;
            conv_end <= '0;
        end
    end

    // High from integrate start to half a period after deintegrate
    always_ff @(posedge CLK or posedge RESET) begin // [RQ14]
        if (RESET) begin
            STATUS <= '0;
        end else if (int_start) begin
            STATUS <= '1;
        end else if (iclk.fall && conv_end) begin
            STATUS <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Handshake sequencer

    logic edge_pend;
    logic trig;

    assign trig = (mode_s & fresh) | edge_pend; // [RQ1] [RQ2]

    // Edges seen during handshake are dropped
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            edge_pend <= '0;
        end else if (hs != HS_IDLE || (iclk.fall && trig)) begin
            edge_pend <= '0; // [RQ4]
        end else if (mode_rise || sw_trig) begin
            edge_pend <= '1; // [RQ2]
        end
    end

    // Entry only on a falling tick, after any latch rise has settled
    always_comb begin // [RQ3]
        next_hs = hs;
        if (iclk.fall) begin
            case (hs) // [RQ6] [RQ15]
                HS_IDLE: begin
                    if (trig) begin
                        next_hs = ready_s ? HS_ARM_HI : HS_WAIT_HI;
                    end
                end
                HS_WAIT_HI: if (ready_s) next_hs = HS_ARM_HI; // [RQ13]
                HS_HOLD_HI: if (ready_s) next_hs = HS_GAP_HI; // [RQ10]
                HS_HOLD_LO: if (ready_s) next_hs = HS_GAP_LO; // [RQ10]
                default: next_hs = hs;
            endcase
        end else if (iclk.rise) begin
            case (hs)
                HS_ARM_HI: next_hs = HS_LOAD_HI; // [RQ7]
                HS_LOAD_HI: next_hs = HS_HOLD_HI; // [RQ8]
                HS_GAP_HI: next_hs = HS_LOAD_LO; // [RQ9] [RQ11]
                HS_LOAD_LO: next_hs = HS_HOLD_LO; // [RQ8]
                HS_GAP_LO: next_hs = HS_IDLE; // [RQ12]
                default: next_hs = hs;
            endcase
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            hs <= HS_IDLE;
        end else begin
            hs <= next_hs;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Pin drivers

    logic drive;
    logic hi_on;
    logic lo_on;

    assign drive = (next_hs != HS_IDLE) | mode_s; // [RQ5] [RQ19]
    assign hi_on = next_hs == HS_LOAD_HI || next_hs == HS_HOLD_HI;
    assign lo_on = next_hs == HS_LOAD_LO || next_hs == HS_HOLD_LO;

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            CTL_OUT <= `CTL_IDLE;
            CTL_OE <= '0;
        end else begin
            CTL_OE <= {3{drive}}; // [RQ5]
            CTL_OUT.load <= !(next_hs == HS_LOAD_HI ||
                next_hs == HS_LOAD_LO); // [RQ8]
            CTL_OUT.upper <= !(hi_on || next_hs == HS_GAP_HI); // [RQ7]
            CTL_OUT.lower <= !(lo_on || next_hs == HS_GAP_LO); // [RQ9]
        end
    end

    // Direct access when the pins act as inputs
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            DATA_OE <= '0;
            DATA_OUT <= '0;
        end else begin
            DATA_OUT <= data_latch;
            if (drive) begin
                DATA_OE <= {hi_on, lo_on}; // [RQ11] [RQ12]
            end else begin
                DATA_OE <= {~ce_s & ~ube_s, ~ce_s & ~lbe_s};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks

    sequence seq_hi_done;
        hs == HS_HOLD_HI && iclk.fall && ready_s;
    endsequence

    sequence seq_lo_done;
        hs == HS_HOLD_LO && iclk.fall && ready_s;
    endsequence

    sequence seq_lo_clear;
        hs == HS_GAP_LO && iclk.rise;
    endsequence

    AST_ENTRY_HELD: assert property ( // [RQ1]
        (hs == HS_IDLE && iclk.fall && mode_s && fresh) |=> hs != HS_IDLE)
        else $error("no handshake after fresh data with mode high");

    AST_ENTRY_WAIT: assert property ( // [RQ13]
        (hs == HS_IDLE && iclk.fall && trig && !ready_s)
        |=> hs == HS_WAIT_HI)
        else $error("entry with ready low did not wait");

    AST_HIGH_START: assert property ( // [RQ7]
        (hs == HS_ARM_HI && iclk.rise)
        |=> !CTL_OUT.load && !CTL_OUT.upper && DATA_OE == 2'h2)
        else $error("high byte did not start");

    AST_LOAD_WIDTH: assert property ( // [RQ8]
        (hs == HS_LOAD_HI && iclk.rise) |=> CTL_OUT.load && DATA_OE[1])
        else $error("load strobe not one period");

    AST_STALL: assert property ( // [RQ10]
        (hs == HS_HOLD_HI && iclk.fall && !ready_s)
        |=> DATA_OE[1] && !CTL_OUT.upper)
        else $error("stall dropped high byte");

    AST_HIGH_OFF: assert property ( // [RQ11]
        seq_hi_done |=> !DATA_OE[1] && !CTL_OUT.upper && CTL_OUT.lower)
        else $error("high data not disabled on ready");

    AST_LOW_START: assert property ( // [RQ11]
        (hs == HS_GAP_HI && iclk.rise) |=> CTL_OUT.upper &&
        !CTL_OUT.lower && !CTL_OUT.load && DATA_OE == 2'h1)
        else $error("low byte did not follow");

    AST_LOW_OFF: assert property ( // [RQ12]
        seq_lo_done |=> DATA_OE == 2'h0 && !CTL_OUT.lower && CTL_OUT.load)
        else $error("low data not disabled on ready");

    AST_END: assert property ( // [RQ12]
        seq_lo_clear |=> hs == HS_IDLE && CTL_OUT == `CTL_IDLE &&
        DATA_OE == 2'h0)
        else $error("handshake did not clear");

    AST_DRIVE: assert property ( // [RQ5]
        hs != HS_IDLE |-> CTL_OE == `CTL_IDLE)
        else $error("control pins not driven in handshake");

    AST_NO_UPDATE: assert property ( // [RQ4]
        $past(hs) != HS_IDLE |-> $stable(data_latch))
        else $error("latch updated during handshake");

    AST_INTEGRATE: assert property ( // [RQ18]
        (phase == PH_INT && iclk.rise && cnt == INT_LAST)
        |=> phase == PH_DE && cnt == '0)
        else $error("integrate length wrong");

endmodule

// ---- rx_partner.sv ----
`timescale 1ns/10ps
module rx_partner
    import adc_hs_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Handshake pins
    input wire ctl_pins_s ctl,
    input wire ctl_pins_s oe,
    input wire logic [13:0] data,
    input wire logic [1:0] data_oe,
    // Bench control
    input wire logic hold,
    input wire logic [7:0] stall,
    // Receiver side
    output logic ready,
    output logic [7:0] hi,
    output logic [7:0] lo,
    output int cnt,
    output int load_w,
    output int hi_w,
    output int bad
);
    logic prev_load;
    logic prev_hoe;
    int lcnt;
    int hcnt;
    int busy;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            prev_load <= 1'b1;
            prev_hoe <= 1'b0;
            lcnt <= 0;
            hcnt <= 0;
            busy <= 0;
            ready <= 1'b0;
            hi <= 8'h00;
            lo <= 8'h00;
            cnt <= 0;
            load_w <= 0;
            hi_w <= 0;
            bad <= 0;
        end else begin
            prev_load <= ctl.load;
            prev_hoe <= data_oe[1];
            lcnt <= (oe.load && !ctl.load) ? lcnt + 1 : 0;
            hcnt <= data_oe[1] ? hcnt + 1 : 0;
            if (prev_hoe && !data_oe[1]) begin
                hi_w <= hcnt;
            end
            // Byte taken on the load rising edge
            if (oe.load && !prev_load && ctl.load) begin
                load_w <= lcnt;
                cnt <= cnt + 1;
                busy <= int'(stall);
                if (!ctl.upper) begin
                    hi <= {2'b00, data[13:8]};
                end
                if (!ctl.lower) begin
                    lo <= data[7:0];
                end
                if (ctl.upper == ctl.lower || data_oe == 2'b00) begin
                    bad <= bad + 1;
                end
            end else if (busy > 0) begin
                busy <= busy - 1;
            end
            // Ready only while the buffer can take a byte
            ready <= !hold && busy == 0;
        end
    end
endmodule

// ---- adc_handshake_output_sequencer_bench.sv ----
`timescale 1ns/10ps
`include "adc_hs_consts.svh"
module adc_handshake_output_sequencer_bench
    import adc_hs_pkg::*;
;
    localparam int DIV = 2;
    localparam int HALF = 8;
    localparam int PER = 2 * HALF;
    logic clk, reset, cyc, stb, we, ack, osc, osc_sel, run_hold, mode;
    logic status, ready, hold;
    logic [7:0] adr, stall, hi, lo;
    logic [3:0] sel;
    logic [31:0] wdat, rdat;
    logic [`DATA_W-1:0] result, dout;
    logic [1:0] doe;
    ctl_pins_s ctl_drv, ctl_in, ctl_out, ctl_oe;
    int cnt, load_w, hi_w, bad, num_errors, n_tests, seed;
    int exp_q[$];

    // Pin level from whoever drives it
    assign ctl_in = ctl_oe.load ? ctl_out : ctl_drv;

    adc_handshake_output_sequencer #(.AZ_PERIODS(4), .INT_PERIODS(8),
        .DEINT_PERIODS(8), .DIV_RATIO(DIV)) adc_handshake_output_sequencer_i (
        .CLK(clk), .RESET(reset), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
        .WB_DAT_O(rdat), .WB_ACK_O(ack), .OSC_IN(osc),
        .OSC_SELECT(osc_sel), .RUN_HOLD(run_hold), .CONV_RESULT(result),
        .STATUS(status), .MODE(mode), .TX_BUFFER_EMPTY(ready),
        .CTL_IN(ctl_in), .CTL_OUT(ctl_out), .CTL_OE(ctl_oe),
        .DATA_OUT(dout), .DATA_OE(doe));

    rx_partner rx_partner_i (.clk(clk), .reset(reset), .ctl(ctl_out),
        .oe(ctl_oe), .data(dout), .data_oe(doe), .hold(hold),
        .stall(stall), .ready(ready), .hi(hi), .lo(lo), .cnt(cnt),
        .load_w(load_w), .hi_w(hi_w), .bad(bad));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial begin
        osc = 1'b0;
        forever begin
            repeat (HALF) @(posedge clk);
            osc <= ~osc;
        end
    end

    ////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what,
                     got, exp);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wait_cnt(input int n);
        int k;
        k = 0;
        while (cnt < n && k < 20000) begin
            @(posedge clk);
            k++;
        end
        check(32'(k < 20000), 32'h0000_0001, "bytes arrived");
    endtask

    task automatic pair_check();
        int v;
        v = exp_q.pop_front();
        check({24'h00_0000, hi}, 32'(v >> 8), "high byte");
        check({24'h00_0000, lo}, 32'(v & 255), "low byte");
    endtask

    task automatic stop_test();
        $display("Counts: %0d checks, %0d mismatches", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (90000) @(posedge clk);
        num_errors++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        stop_test();
    end

    initial begin
        int i, n, rises;
        logic prev;
        logic [31:0] q;
        seed = 32'h4603_1b5a;
        num_errors = 0;
        n_tests = 0;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        sel = 4'h1;
        wdat = 32'h0000_0000;
        osc_sel = 1'b1;
        run_hold = 1'b1;
        mode = 1'b1;
        hold = 1'b0;
        stall = 8'h00;
        ctl_drv = `CTL_IDLE;
        result = `DATA_W'($random(seed));
        reset = 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        wb(1'b0, `REG_CTRL, 32'h0000_0000, q);
        check(q, `CTRL_RESET, "ctrl reset");
        wb(1'b1, 8'h40, 32'hffff_ffff, q);
        wb(1'b0, 8'h40, 32'h0000_0000, q);
        check(q, 32'h0000_0000, "unmapped read");
        wb(1'b0, `REG_STATUS, 32'h0000_0000, q);
        check(q & 32'h0000_0001, 32'h0000_0000, "handshake idle");
        $display("Test registers done");
        // Mode high out of reset is an edge: reset latch sent first
        exp_q.push_back(0);
        exp_q.push_back(int'(result));
        wait_cnt(2);
        pair_check();
        wait_cnt(4);
        pair_check();
        check(32'(load_w), 32'(PER), "load width");
        check(32'(hi_w), 32'(PER * 3 / 2), "data width");
        check(32'(ctl_oe), 32'h7, "pins driven");
        mode <= 1'b0;
        repeat (1000) @(posedge clk);
        check(32'(ctl_oe), 32'h0, "pins released");
        check(32'(cnt % 2), 32'h0, "whole pairs");
        $display("Test level trigger done");
        for (i = 0; i < 3; i++) begin
            result <= `DATA_W'($random(seed));
            stall <= 8'($random(seed) & 63);
            hold <= (i == 0);
            repeat (800) @(posedge clk);
            exp_q.push_back(int'(result));
            n = cnt;
            mode <= 1'b1;
            repeat (40) @(posedge clk);
            mode <= 1'b0;
            if (i == 0) begin
                rises = 0;
                prev = status;
                result <= ~result;
                repeat (800) begin
                    @(posedge clk);
                    rises += int'(status && !prev);
                    prev = status;
                end
                check(32'(cnt), 32'(n), "waits for ready");
                check(32'(rises >= 2), 32'h1, "status runs");
                hold <= 1'b0;
            end
            wait_cnt(n + 2);
            pair_check();
            repeat (120) @(posedge clk);
            check(32'(ctl_oe), 32'h0, "back to direct");
        end
        $display("Test pulse trigger done");
        osc_sel <= 1'b0;
        stall <= 8'h00;
        result <= `DATA_W'($random(seed));
        repeat (2000) @(posedge clk);
        exp_q.push_back(int'(result));
        n = cnt;
        wb(1'b1, `REG_CTRL, 32'h0000_0003, q);
        wait_cnt(n + 2);
        pair_check();
        check(32'(load_w), 32'(PER * DIV), "divided load");
        check(32'(hi_w), 32'(PER * DIV * 3 / 2), "divided data");
        osc_sel <= 1'b1;
        $display("Test divided clock done");
        repeat (300) @(posedge clk);
        check(32'(ctl_oe), 32'h0, "released after trigger");
        check(32'(doe), 32'h0, "direct idle");
        ctl_drv <= 3'h2;
        repeat (4) @(posedge clk);
        check(32'(doe), 32'h1, "direct low byte");
        ctl_drv <= 3'h1;
        repeat (4) @(posedge clk);
        check(32'(doe), 32'h2, "direct high byte");
        check(32'(bad), 32'h0, "byte flags");
        ctl_drv <= `CTL_IDLE;
        $display("Test direct mode done");
        stop_test();
    end
endmodule
